// file: src/flash_device.sv
// The implementer's own choices: the plain strobed port.
module flash_device #(
  parameter int MEM_BYTES = 256,
  parameter int AW        = $clog2(MEM_BYTES)
) (
  input  wire logic          core_clk,
  input  wire logic          srst,
  flash_link_if.device       link,
  input  wire logic [7:0]    status_reg2,
  input  wire logic          suspend_set,
  input  wire logic          op_start,
  input  wire logic          op_done,
  input  wire logic          op_security,
  input  wire logic          mem_we,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [7:0]    mem_wdata,
  output logic               busy,
  output logic               suspend_flag,
  output logic               resume_go,
  output logic               cont_quad,
  output logic               cont_dual
);

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_CMD   = 7'b0000010,
    S_ADDR  = 7'b0000100,
    S_MODE  = 7'b0001000,
    S_DUMMY = 7'b0010000,
    S_DATA  = 7'b0100000,
    S_SKIP  = 7'b1000000
  } dev_state_t;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [5:0]  pin_q;
  logic        cs_q;
  logic        sclk_q;
  logic [3:0]  io_q;
  logic        sclk_d;
  logic        cs_d;
  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic        cs_rise;

  // Chip select resets high so no false frame start leaves reset
  edge_sync #(.W(6), .INIT(6'h20)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .d        ({link.cs_n, link.sclk, link.io}),
    .q        (pin_q)
  );

  assign cs_q    = pin_q[5];
  assign sclk_q  = pin_q[4];
  assign io_q    = pin_q[3:0];
  assign rise    = sclk_q & ~sclk_d & ~cs_q;
  assign fall    = ~sclk_q & sclk_d & ~cs_q;
  assign cs_fall = ~cs_q & cs_d;
  assign cs_rise = cs_q & ~cs_d;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= sclk_q;
      cs_d   <= cs_q;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  dev_state_t    state;
  logic [7:0]    op;
  logic [31:0]   sh;
  logic [31:0]   next_sh;
  logic [4:0]    cnt;
  logic [4:0]    plen;
  logic [2:0]    in_lanes;
  logic          last;
  logic          pend_resume;
  logic          mode_done;
  logic          addr_done;
  logic [7:0]    new_op;

  assign new_op    = next_sh[7:0];
  assign last      = (cnt == plen - 5'd1);
  assign mode_done = rise && (state == S_MODE) && last;
  assign addr_done = rise && (state == S_ADDR) && last;

  always_comb begin
    in_lanes = (state == S_CMD) ? 3'd1 : flash_pkg::addr_lanes(op);
    case (in_lanes)
      3'd2:    next_sh = {sh[29:0], io_q[1:0]};
      3'd4:    next_sh = {sh[27:0], io_q};
      default: next_sh = {sh[30:0], io_q[0]};
    endcase
    case (state)
      S_CMD:   plen = 5'(flash_pkg::CMD_CLKS);
      S_ADDR:  plen = flash_pkg::phase_clks(in_lanes, flash_pkg::ADDR_BITS);
      S_MODE:  plen = flash_pkg::phase_clks(in_lanes, flash_pkg::BYTE_BITS);
      S_DUMMY: plen = flash_pkg::dummy_clks(op);
      default: plen = 5'd0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state       <= S_IDLE;
      op          <= 8'h00;
      sh          <= 32'h0;
      cnt         <= 5'd0;
      pend_resume <= 1'b0;
    end else if (cs_q) begin
      state <= S_IDLE;
      cnt   <= 5'd0;
    end else if (cs_fall) begin
      cnt         <= 5'd0;
      pend_resume <= 1'b0;
      if (cont_quad) begin
        state <= S_ADDR;
        op    <= flash_pkg::OP_QIO;
      end else if (cont_dual) begin
        state <= S_ADDR;
        op    <= flash_pkg::OP_DIO;
      end else begin
        state <= S_CMD;
      end
    end else if (rise) begin
      sh  <= next_sh;
      cnt <= last ? 5'd0 : cnt + 5'd1;
      case (state)
        S_CMD: if (last) begin
          op <= new_op;
          if (new_op == flash_pkg::OP_RESUME) begin
            // Acted on only at chip select rise after exactly eight bits
            pend_resume <= suspend_flag & ~busy & ~op_security;
            state       <= S_SKIP;
          end else if (flash_pkg::is_read(new_op) && !busy &&
                       (!flash_pkg::needs_qe(new_op) ||
                        status_reg2[flash_pkg::QE_BIT])) begin
            state <= S_ADDR;
          end else begin
            state <= S_SKIP;
          end
        end
        S_ADDR: if (last) begin
          if (flash_pkg::has_mode(op))
            state <= S_MODE;
          else if (flash_pkg::dummy_clks(op) != 5'd0)
            state <= S_DUMMY;
          else
            state <= S_DATA;
        end
        S_MODE: if (last) begin
          state <= (flash_pkg::dummy_clks(op) != 5'd0) ? S_DUMMY : S_DATA;
        end
        S_DUMMY: if (last) begin
          state <= S_DATA;
        end
        S_SKIP:  pend_resume <= 1'b0;
        default: state <= state;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Continuous read mode
  // ---------------------------------------------------------------
  // Only the mode byte moves these; reset commands leave them alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cont_quad <= 1'b0;
      cont_dual <= 1'b0;
    end else if (mode_done) begin
      cont_quad <= (op == flash_pkg::OP_QIO) &&
                   (next_sh[5:4] == flash_pkg::CONT_ENTER);
      cont_dual <= (op == flash_pkg::OP_DIO) &&
                   (next_sh[5:4] == flash_pkg::CONT_ENTER);
    end
  end

  // ---------------------------------------------------------------
  // Array and read data
  // ---------------------------------------------------------------
  logic [7:0]  mem [MEM_BYTES];
  logic [23:0] raddr;
  logic [7:0]  dbyte;
  logic [7:0]  cur_byte;
  logic [2:0]  bcnt;
  logic [2:0]  dl;
  logic [3:0]  dout;
  logic [3:0]  doe;

  always_ff @(posedge core_clk) begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  assign dl       = flash_pkg::data_lanes(op);
  assign cur_byte = (bcnt == 3'd0) ? mem[raddr[AW-1:0]] : dbyte;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      raddr <= 24'h0;
      dbyte <= 8'h00;
      bcnt  <= 3'd0;
      dout  <= 4'h0;
      doe   <= 4'h0;
    end else if (cs_q) begin
      bcnt <= 3'd0;
      doe  <= 4'h0;
    end else if (addr_done) begin
      raddr <= next_sh[23:0];
      bcnt  <= 3'd0;
    end else if (fall && state == S_DATA) begin
      dbyte <= 8'(cur_byte << dl);
      if (bcnt == 3'd0) begin
        raddr <= raddr + 24'd1;
        bcnt  <= 3'(flash_pkg::BYTE_BITS / int'(dl) - 1);
      end else begin
        bcnt <= bcnt - 3'd1;
      end
      case (dl)
        3'd2: begin
          dout <= {2'b00, cur_byte[7:6]};
          doe  <= 4'b0011;
        end
        3'd4: begin
          dout <= cur_byte[7:4];
          doe  <= 4'b1111;
        end
        default: begin
          dout <= {2'b00, cur_byte[7], 1'b0};
          doe  <= 4'b0010;
        end
      endcase
    end
  end

  assign link.dev_io_o  = dout;
  assign link.dev_io_oe = doe;

  // ---------------------------------------------------------------
  // Suspend, busy and resume
  // ---------------------------------------------------------------
  logic       accept;
  logic [5:0] rtmr;

  // Accept comes three cycles after the pin: sync, edge, accept
  // Loading less keeps busy inside the limit measured at the pin
  localparam int PIN_LAG = 3;

  assign accept = cs_rise & pend_resume;

  always_ff @(posedge core_clk) begin
    if (srst)
      suspend_flag <= 1'b0;
    else if (suspend_set)
      suspend_flag <= 1'b1;
    else if (accept)
      suspend_flag <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rtmr      <= 6'd0;
      resume_go <= 1'b0;
    end else begin
      resume_go <= (rtmr == 6'd1);
      if (accept)
        rtmr <= 6'(flash_pkg::RESUME_BUSY_CYC - PIN_LAG);
      else if (rtmr != 6'd0)
        rtmr <= rtmr - 6'd1;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst)
      busy <= 1'b0;
    else if (op_start || rtmr == 6'd1)
      busy <= 1'b1;
    else if (suspend_set || op_done)
      busy <= 1'b0;
  end

endmodule

// file: src/flash_pkg.sv
package flash_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int RESUME_BUSY_NS  = 200;
  // Longest time, so rounded down
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
  localparam int LINK_HALF_CYC   = 8;
  localparam int SUSPEND_RECOVERY_CYC = 4000;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int CMD_CLKS       = 8;
  localparam int BYTE_BITS      = 8;
  localparam int ADDR_BITS      = 24;
  localparam int FAST_DUMMY     = 8;
  localparam int QIO_DUMMY      = 4;
  localparam int EXIT_QUAD_CLKS = 8;
  localparam int EXIT_DUAL_CLKS = 16;
  localparam int QE_BIT         = 1;
  localparam logic [1:0] CONT_ENTER = 2'b10;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RESUME   = 8'h7a;
  localparam logic [7:0] OP_SUSPEND  = 8'h75;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FAST     = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DIO      = 8'hbb;
  localparam logic [7:0] OP_QIO      = 8'heb;
  localparam logic [7:0] OP_RST_EN   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;

  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    case (op)
      OP_DIO:  addr_lanes = 3'd2;
      OP_QIO:  addr_lanes = 3'd4;
      default: addr_lanes = 3'd1;
    endcase
  endfunction

  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    case (op)
      OP_DUAL_OUT, OP_DIO: data_lanes = 3'd2;
      OP_QUAD_OUT, OP_QIO: data_lanes = 3'd4;
      default:             data_lanes = 3'd1;
    endcase
  endfunction

  function automatic logic [4:0] phase_clks(input logic [2:0] lanes, input int bits);
    phase_clks = 5'(bits / int'(lanes));
  endfunction

  function automatic logic [4:0] dummy_clks(input logic [7:0] op);
    case (op)
      OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT: dummy_clks = 5'(FAST_DUMMY);
      OP_QIO:                            dummy_clks = 5'(QIO_DUMMY);
      default:                           dummy_clks = 5'd0;
    endcase
  endfunction

  function automatic logic has_mode(input logic [7:0] op);
    has_mode = (op == OP_DIO) || (op == OP_QIO);
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ) || (op == OP_FAST) || (op == OP_DUAL_OUT) ||
              (op == OP_QUAD_OUT) || has_mode(op);
  endfunction

  function automatic logic needs_qe(input logic [7:0] op);
    needs_qe = (op == OP_QUAD_OUT) || (op == OP_QIO);
  endfunction

endpackage

// file: src/flash_link_if.sv
interface flash_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Undriven lines float high through the pull-up
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o) |
              (~dev_io_oe & ~host_io_oe);

  modport host(output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
  modport device(input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface

// file: src/edge_sync.sv
module edge_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// file: src/flash_host.sv
module flash_host #(
  parameter int HALF_CYC     = flash_pkg::LINK_HALF_CYC,
  parameter int RECOVERY_CYC = flash_pkg::SUSPEND_RECOVERY_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  flash_link_if.host       link,
  input  wire logic        cmd_start,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [7:0]  cmd_mode,
  input  wire logic [15:0] cmd_len,
  input  wire logic        cmd_no_opcode,
  input  wire logic        cmd_exit,
  output logic             cmd_ready,
  output logic             cmd_done,
  output logic             rd_valid,
  output logic [7:0]       rd_data
);

  typedef enum logic [6:0] {
    H_IDLE  = 7'b0000001,
    H_CMD   = 7'b0000010,
    H_ADDR  = 7'b0000100,
    H_MODE  = 7'b0001000,
    H_DUMMY = 7'b0010000,
    H_DATA  = 7'b0100000,
    H_END   = 7'b1000000
  } host_state_t;

  host_state_t state;
  host_state_t nxt_state;
  logic [3:0]  io_q;
  logic [7:0]  div;
  logic        tick;
  logic        lvl;
  logic        cs_n;
  logic        sclk;
  logic [3:0]  io_o;
  logic [3:0]  io_oe;
  logic [7:0]  op;
  logic [23:0] addr;
  logic [7:0]  mode;
  logic [15:0] left;
  logic        exit_f;
  logic [31:0] tx;
  logic [31:0] nxt_tx;
  logic [4:0]  cnt;
  logic [4:0]  plen;
  logic [4:0]  nxt_plen;
  logic [2:0]  al;
  logic [2:0]  dl;
  logic [2:0]  ln;
  logic [7:0]  rx;
  logic [15:0] recov;

  edge_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .d        (link.io),
    .q        (io_q)
  );

  assign tick = (div == 8'(HALF_CYC - 1));
  assign al   = flash_pkg::addr_lanes(op);
  assign dl   = flash_pkg::data_lanes(op);
  assign ln   = (state == H_CMD) ? 3'd1 : al;

  // ---------------------------------------------------------------
  // Phase after the current one
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = H_END;
    nxt_plen  = 5'd0;
    nxt_tx    = tx;
    case (state)
      H_CMD: if (!exit_f && flash_pkg::is_read(op)) begin
        nxt_state = H_ADDR;
        nxt_plen  = flash_pkg::phase_clks(al, flash_pkg::ADDR_BITS);
        nxt_tx    = {addr, 8'h00};
      end
      H_ADDR: if (flash_pkg::has_mode(op)) begin
        nxt_state = H_MODE;
        nxt_plen  = flash_pkg::phase_clks(al, flash_pkg::BYTE_BITS);
        nxt_tx    = {mode, 24'h0};
      end else if (flash_pkg::dummy_clks(op) != 5'd0) begin
        nxt_state = H_DUMMY;
        nxt_plen  = flash_pkg::dummy_clks(op);
      end else begin
        nxt_state = H_DATA;
      end
      H_MODE: if (flash_pkg::dummy_clks(op) != 5'd0) begin
        nxt_state = H_DUMMY;
        nxt_plen  = flash_pkg::dummy_clks(op);
      end else begin
        nxt_state = H_DATA;
      end
      H_DUMMY: nxt_state = H_DATA;
      H_DATA:  nxt_state = (left > 16'd1) ? H_DATA : H_END;
      default: nxt_state = H_END;
    endcase
    if (nxt_state == H_DATA) begin
      nxt_plen = flash_pkg::phase_clks(dl, flash_pkg::BYTE_BITS);
      if (left == 16'd0)
        nxt_state = H_END;
    end
  end

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= H_IDLE;
      div <= 8'd0; lvl <= 1'b0; cs_n <= 1'b1; sclk <= 1'b0;
      io_o <= 4'h0; io_oe <= 4'h0; op <= 8'h00; addr <= 24'h0;
      mode <= 8'h00; left <= 16'h0; exit_f <= 1'b0; tx <= 32'h0;
      cnt <= 5'd0; plen <= 5'd0; rx <= 8'h00;
      cmd_ready <= 1'b1; cmd_done <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00;
    end else begin
      cmd_done <= 1'b0;
      rd_valid <= 1'b0;
      div      <= (state == H_IDLE || tick) ? 8'd0 : div + 8'd1;
      if (state == H_IDLE) begin
        if (cmd_start && !(cmd_op == flash_pkg::OP_SUSPEND && recov != 16'd0)) begin
          op <= cmd_op; addr <= cmd_addr; mode <= cmd_mode; left <= cmd_len;
          exit_f <= cmd_exit; cs_n <= 1'b0; lvl <= 1'b1; cnt <= 5'd0;
          cmd_ready <= 1'b0;
          if (cmd_exit) begin
            state <= H_CMD;
            tx    <= 32'hffff_ffff;
            plen  <= (cmd_op == flash_pkg::OP_DIO) ? 5'(flash_pkg::EXIT_DUAL_CLKS)
                                                   : 5'(flash_pkg::EXIT_QUAD_CLKS);
          end else if (cmd_no_opcode) begin
            state <= H_ADDR;
            tx    <= {cmd_addr, 8'h00};
            plen  <= flash_pkg::phase_clks(flash_pkg::addr_lanes(cmd_op),
                                           flash_pkg::ADDR_BITS);
          end else begin
            state <= H_CMD;
            tx    <= {cmd_op, 24'h0};
            plen  <= 5'(flash_pkg::CMD_CLKS);
          end
        end
      end else if (tick && lvl) begin
        // Falling edge: present the next bits
        lvl  <= 1'b0;
        sclk <= 1'b0;
        case (state)
          H_CMD, H_ADDR, H_MODE: begin
            tx <= tx << ln;
            case (ln)
              3'd2:    begin io_o <= {2'b00, tx[31:30]}; io_oe <= 4'b0011; end
              3'd4:    begin io_o <= tx[31:28];          io_oe <= 4'b1111; end
              default: begin io_o <= {3'b000, tx[31]};   io_oe <= 4'b0001; end
            endcase
            if (state == H_MODE && cnt >= (plen >> 1))
              io_oe <= 4'h0;
          end
          H_END: begin
            cs_n      <= 1'b1;
            io_oe     <= 4'h0;
            state     <= H_IDLE;
            cmd_done  <= 1'b1;
            cmd_ready <= 1'b1;
          end
          default: io_oe <= 4'h0;
        endcase
      end else if (tick) begin
        // Rising edge: the device samples, we take read data
        lvl  <= 1'b1;
        sclk <= 1'b1;
        cnt  <= (cnt == plen - 5'd1) ? 5'd0 : cnt + 5'd1;
        if (state == H_DATA) begin
          case (dl)
            3'd2:    rx <= {rx[5:0], io_q[1:0]};
            3'd4:    rx <= {rx[3:0], io_q};
            default: rx <= {rx[6:0], io_q[1]};
          endcase
        end
        if (cnt == plen - 5'd1) begin
          state <= nxt_state;
          plen  <= nxt_plen;
          tx    <= nxt_tx;
          if (state == H_DATA) begin
            rd_valid <= 1'b1;
            left     <= left - 16'd1;
            case (dl)
              3'd2:    rd_data <= {rx[5:0], io_q[1:0]};
              3'd4:    rd_data <= {rx[3:0], io_q};
              default: rd_data <= {rx[6:0], io_q[1]};
            endcase
          end
        end
      end
    end
  end

  // Blocks a suspend until the device has had time to resume
  always_ff @(posedge core_clk) begin
    if (srst)
      recov <= 16'd0;
    else if (tick && lvl && state == H_END && op == flash_pkg::OP_RESUME && !exit_f)
      recov <= 16'(RECOVERY_CYC);
    else if (recov != 16'd0)
      recov <= recov - 16'd1;
  end

  assign link.cs_n       = cs_n;
  assign link.sclk       = sclk;
  assign link.host_io_o  = io_o;
  assign link.host_io_oe = io_oe;

endmodule

// file: test/flash_link_sva.sv
module flash_link_sva (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_NO_FIGHT: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("both ends drive io");
  AST_DEV_OFF: assert property (cs_n [*8] |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  AST_SCLK_IDLE: assert property (cs_n [*2] |-> !sclk)
    else $error("sclk runs outside frame");
  AST_DEV_ON_FALL: assert property ((dev_io_oe != 4'h0) && $changed(dev_io_o) |-> !sclk)
    else $error("device data changed in high phase");
  AST_HOST_HOLD: assert property ($rose(sclk) |=> $stable(host_io_o & host_io_oe) [*4])
    else $error("host bit moved around rise");
  AST_LANES: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal device lane set");
  AST_FRAME_OPEN: assert property ($fell(cs_n) |-> (!cs_n && !sclk) [*8])
    else $error("frame opened badly");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase not 8 cycles");
endmodule

// file: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, srst, cmd_start, cmd_no_opcode, cmd_exit, cmd_ready, cmd_done;
  logic        rd_valid, suspend_set, op_start, op_done, op_security, mem_we;
  logic        busy, suspend_flag, resume_go, cont_quad, cont_dual;
  logic [7:0]  cmd_op, cmd_mode, rd_data, status_reg2, mem_addr, mem_wdata;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_len;
  logic [31:0] seed = 32'h358d2f41;
  logic [7:0]  mem_m [256];
  logic [7:0]  got [$];
  logic [7:0]  ops [6] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb};
  int          bad_count, samples_checked, n;
  realtime     t_cs;
  flash_link_if link ();
  flash_host #(.RECOVERY_CYC(20)) u_flash_host (.core_clk, .srst, .link(link.host),
    .cmd_start, .cmd_op, .cmd_addr, .cmd_mode, .cmd_len, .cmd_no_opcode, .cmd_exit,
    .cmd_ready, .cmd_done, .rd_valid, .rd_data);
  flash_device #(.MEM_BYTES(256)) u_flash_device (.core_clk, .srst, .link(link.device),
    .status_reg2, .suspend_set, .op_start, .op_done, .op_security, .mem_we, .mem_addr,
    .mem_wdata, .busy, .suspend_flag, .resume_go, .cont_quad, .cont_dual);
  flash_link_sva u_flash_link_sva (.core_clk, .srst, .cs_n(link.cs_n), .sclk(link.sclk),
    .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o),
    .dev_io_oe(link.dev_io_oe), .io(link.io));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Ignored frames read back the pull-up level
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                     input logic [15:0] len, input logic noop, ex, live);
    got = {};
    @(posedge core_clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_mode <= m;
    cmd_len <= len;
    cmd_no_opcode <= noop;
    cmd_exit <= ex;
    cmd_start <= 1'b1;
    @(posedge core_clk);
    cmd_start <= 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    // Chip select rose one cycle before cmd_done was seen
    t_cs = $realtime - flash_pkg::CLK_PERIOD_NS;
    chk("cmd_done", 8'h01, {7'h0, cmd_done === 1'b1});
    chk("bytes", len[7:0], 8'(got.size()));
    for (int i = 0; i < got.size(); i++)
      chk("rd_data", live ? mem_m[8'(a + i)] : 8'hff, got[i]);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
  initial begin
    {srst, cmd_start, cmd_no_opcode, cmd_exit, suspend_set, op_start} = 6'h20;
    {op_done, op_security, mem_we, cmd_addr, cmd_len} = '0;
    {cmd_op, cmd_mode, status_reg2, mem_addr, mem_wdata} = 40'h0000020000;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      mem_m[i] = seed[7:0];
      mem_we <= 1'b1;
      mem_addr <= 8'(i);
      mem_wdata <= seed[7:0];
      @(posedge core_clk);
    end
    mem_we <= 1'b0;
    foreach (ops[i]) begin
      seed = lfsr(seed);
      run(ops[i], seed[23:0], 8'h00, 16'h3, 1'b0, 1'b0, 1'b1);
    end
    status_reg2 <= 8'h00;
    run(8'h6b, 24'h10, 8'h00, 16'h2, 1'b0, 1'b0, 1'b0);
    run(8'heb, 24'h10, 8'h00, 16'h2, 1'b0, 1'b0, 1'b0);
    status_reg2 <= 8'h02;
    run(8'heb, 24'h40, 8'h20, 16'h2, 1'b0, 1'b0, 1'b1);
    chk("cont_quad", 8'h01, {7'h0, cont_quad});
    run(8'heb, 24'h80, 8'h20, 16'h2, 1'b1, 1'b0, 1'b1);
    run(8'heb, 24'h00, 8'hff, 16'h0, 1'b0, 1'b1, 1'b0);
    chk("cont_quad", 8'h00, {7'h0, cont_quad});
    run(8'hbb, 24'h33, 8'h2f, 16'h2, 1'b0, 1'b0, 1'b1);
    chk("cont_dual", 8'h01, {7'h0, cont_dual});
    run(8'hbb, 24'h55, 8'hf0, 16'h2, 1'b1, 1'b0, 1'b1);
    chk("cont_dual", 8'h00, {7'h0, cont_dual});
    run(8'hbb, 24'h66, 8'h20, 16'h2, 1'b0, 1'b0, 1'b1);
    chk("cont_dual", 8'h01, {7'h0, cont_dual});
    run(8'hbb, 24'h00, 8'hff, 16'h0, 1'b0, 1'b1, 1'b0);
    chk("cont_dual", 8'h00, {7'h0, cont_dual});
    op_start <= 1'b1;
    @(posedge core_clk);
    op_start <= 1'b0;
    run(8'h03, 24'h00, 8'h00, 16'h1, 1'b0, 1'b0, 1'b0);
    run(8'h7a, 24'h00, 8'h00, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("busy", 8'h01, {7'h0, busy});
    suspend_set <= 1'b1;
    op_security <= 1'b1;
    @(posedge core_clk);
    suspend_set <= 1'b0;
    run(8'h7a, 24'h00, 8'h00, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("suspend_flag", 8'h01, {7'h0, suspend_flag});
    op_security <= 1'b0;
    run(8'h7a, 24'h00, 8'h00, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("suspend_flag", 8'h00, {7'h0, suspend_flag});
    // A suspend inside the recovery time must not open a frame
    cmd_op <= flash_pkg::OP_SUSPEND;
    cmd_start <= 1'b1;
    @(posedge core_clk);
    cmd_start <= 1'b0;
    @(posedge core_clk);
    chk("cmd_ready", 8'h01, {7'h0, cmd_ready});
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    // Busy was set one edge before it was seen
    chk("busy_delay", 8'h01, {7'h0, busy === 1'b1 &&
        $realtime - flash_pkg::CLK_PERIOD_NS - t_cs <= flash_pkg::RESUME_BUSY_NS});
    chk("resume_go", 8'h01, {7'h0, resume_go});
    op_done <= 1'b1;
    @(posedge core_clk);
    op_done <= 1'b0;
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule
